// ---- cowd_code_option_word_decode.sv ----
// configuration word decoder: option word and two customer id words
// assumes words are loaded by the programmer via a load strobe, never
// by running code
//
// Summary of operation
// R01: option words unreachable from running program code
// R02: three 13-bit words: options, two id
// R03: word zero bits twelve to nine ignored
// R04: bit eight picks two or four periods
// R05: bit seven low enables the watchdog
// R06: bit six picks one or two branch cycles
// R07: bit four picks RC or crystal oscillator
// R08: bit three picks low or high power
// R09: protection off only when protect bits 111
// R10: id words store all thirteen bits
// R11: timer clock quarter rate in four-period mode
// R12: word zero bit five ignored
`timescale 1ns/10ps
module cowd_code_option_word_decode
(
  input wire logic clk,
  input wire logic reset,
  input wire logic progLoad,
  input wire logic [1:0] progWordSel,
  input wire logic [12:0] progWordData,
  output logic cycleLengthSelect,
  output logic [2:0] oscPeriodsPerCycle,
  output logic watchdogEnable,
  output logic branchCycleSelect,
  output logic [1:0] branchCycles,
  output logic crystalSelect,
  output logic drivePowerSelect,
  output logic writeProtectEnable,
  output logic [2:0] timerClockDivide,
  output logic [12:0] customerId1,
  output logic [12:0] customerId2
);
  // true when the programming port writes word idx in this cycle
  function automatic logic load_hit(
    input logic load,
    input logic [1:0] sel,
    input logic [1:0] idx
  );
    load_hit = load && (sel == idx);
  endfunction : load_hit

  // oscillator periods per instruction cycle, also the timer divide
  function automatic logic [2:0] cycle_divide(input logic fourPeriods);
    if (fourPeriods)
    begin
      cycle_divide = cowd_pkg::DIV_LONG;
    end
    else
    begin
      cycle_divide = cowd_pkg::DIV_SHORT;
    end
  endfunction : cycle_divide

  // instruction cycles taken by a jump or call
  function automatic logic [1:0] branch_count(input logic twoCycles);
    if (twoCycles)
    begin
      branch_count = cowd_pkg::BR_LONG;
    end
    else
    begin
      branch_count = cowd_pkg::BR_SHORT;
    end
  endfunction : branch_count

  // any code but all ones keeps the program memory protected
  function automatic logic protect_on(input logic [2:0] code);
    protect_on = (code != cowd_pkg::PROT_OFF_CODE);
  endfunction : protect_on

  // only the programming port writes; no program-side access exists
  logic [12:0] optWord_q; // R01
  logic [12:0] optWord_d;

  always_comb
  begin
    optWord_d = optWord_q;
    if (load_hit(progLoad, progWordSel, cowd_pkg::SEL_OPTION))
    begin
      optWord_d = progWordData; // R02
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      optWord_q <= cowd_pkg::OPT_RESET;
    end
    else
    begin
      optWord_q <= optWord_d; // R01
    end
  end

  // one register per customer id word
  for (genvar g = 0; g < cowd_pkg::ID_WORDS; g++)
  begin : g_id
    localparam logic [1:0] WORD_SEL = 2'(cowd_pkg::SEL_ID1 + g);
    logic [12:0] idWord_q;

    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        idWord_q <= cowd_pkg::ID_RESET;
      end
      else if (load_hit(progLoad, progWordSel, WORD_SEL))
      begin
        idWord_q <= progWordData; // R10
      end
    end
  end

  // decoded settings; bits 12..9 and 5 feed none of them // R03 R12
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cycleLengthSelect <= cowd_pkg::OPT_RESET[cowd_pkg::CYCLE_LEN_BIT];
      oscPeriodsPerCycle <=
        cycle_divide(cowd_pkg::OPT_RESET[cowd_pkg::CYCLE_LEN_BIT]);
    end
    else
    begin
      cycleLengthSelect <= optWord_q[cowd_pkg::CYCLE_LEN_BIT]; // R04
      oscPeriodsPerCycle <=
        cycle_divide(optWord_q[cowd_pkg::CYCLE_LEN_BIT]); // R04
    end
  end

  // timer source follows the instruction cycle length
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      timerClockDivide <=
        cycle_divide(cowd_pkg::OPT_RESET[cowd_pkg::CYCLE_LEN_BIT]);
    end
    else
    begin
      timerClockDivide <=
        cycle_divide(optWord_q[cowd_pkg::CYCLE_LEN_BIT]); // R11
    end
  end

  // active-low option bit, active-high enable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      watchdogEnable <= ~cowd_pkg::OPT_RESET[cowd_pkg::WDOG_DIS_BIT];
    end
    else
    begin
      watchdogEnable <= ~optWord_q[cowd_pkg::WDOG_DIS_BIT]; // R05
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      branchCycleSelect <= cowd_pkg::OPT_RESET[cowd_pkg::BRANCH_CYC_BIT];
      branchCycles <=
        branch_count(cowd_pkg::OPT_RESET[cowd_pkg::BRANCH_CYC_BIT]);
    end
    else
    begin
      branchCycleSelect <= optWord_q[cowd_pkg::BRANCH_CYC_BIT]; // R06
      branchCycles <=
        branch_count(optWord_q[cowd_pkg::BRANCH_CYC_BIT]); // R06
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      crystalSelect <= cowd_pkg::OPT_RESET[cowd_pkg::OSC_TYPE_BIT];
    end
    else
    begin
      crystalSelect <= optWord_q[cowd_pkg::OSC_TYPE_BIT]; // R07
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      drivePowerSelect <= cowd_pkg::OPT_RESET[cowd_pkg::DRIVE_PWR_BIT];
    end
    else
    begin
      drivePowerSelect <= optWord_q[cowd_pkg::DRIVE_PWR_BIT]; // R08
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      writeProtectEnable <= protect_on(
        cowd_pkg::OPT_RESET[cowd_pkg::PROT_MSB:cowd_pkg::PROT_LSB]);
    end
    else
    begin
      writeProtectEnable <= protect_on(
        optWord_q[cowd_pkg::PROT_MSB:cowd_pkg::PROT_LSB]); // R09
    end
  end

  // id words reach the outputs one edge after they are stored
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      customerId1 <= cowd_pkg::ID_RESET;
      customerId2 <= cowd_pkg::ID_RESET;
    end
    else
    begin
      customerId1 <= g_id[0].idWord_q; // R10
      customerId2 <= g_id[1].idWord_q; // R10
    end
  end

  // write strobes as seen by the checks below
  sequence seq_option_write;
    progLoad && (progWordSel == cowd_pkg::SEL_OPTION);
  endsequence
  sequence seq_id1_write;
    progLoad && (progWordSel == cowd_pkg::SEL_ID1);
  endsequence
  sequence seq_id2_write;
    progLoad && (progWordSel == cowd_pkg::SEL_ID2);
  endsequence
  // one edge to store the word, one more to decode it
  sequence seq_option_walk;
    seq_option_write ##1 1'b1;
  endsequence

  chk_option_load: assert property (@(posedge clk) // R02
    disable iff (reset)
    seq_option_write |=> optWord_q == $past(progWordData))
    else $error("option word not stored");
  chk_option_kept: assert property (@(posedge clk) // R01
    disable iff (reset)
    !(progLoad && (progWordSel == cowd_pkg::SEL_OPTION)) |=>
    $stable(optWord_q))
    else $error("option word changed without a load");
  chk_id_load: assert property (@(posedge clk) // R10
    disable iff (reset)
    seq_id1_write |=> ##1 customerId1 == $past(progWordData, 2))
    else $error("id word not stored");
  chk_id2_load: assert property (@(posedge clk) // R10
    disable iff (reset)
    seq_id2_write |=> ##1 customerId2 == $past(progWordData, 2))
    else $error("second id word not stored");
  chk_id_kept: assert property (@(posedge clk) // R01 R10
    disable iff (reset)
    !progLoad |=> $stable(g_id[0].idWord_q) && $stable(g_id[1].idWord_q))
    else $error("id word changed without a load");
  chk_unused_select: assert property (@(posedge clk) // R02
    disable iff (reset)
    progLoad && (progWordSel == 2'h3) |=> $stable(optWord_q) &&
    $stable(g_id[0].idWord_q) && $stable(g_id[1].idWord_q))
    else $error("unused word index changed a word");
  chk_cycle_length: assert property (@(posedge clk) // R04
    disable iff (reset)
    oscPeriodsPerCycle == ($past(optWord_q[cowd_pkg::CYCLE_LEN_BIT]) ?
    cowd_pkg::DIV_LONG : cowd_pkg::DIV_SHORT))
    else $error("cycle length wrong");
  chk_cycle_select: assert property (@(posedge clk) // R04
    disable iff (reset)
    cycleLengthSelect == $past(optWord_q[cowd_pkg::CYCLE_LEN_BIT]))
    else $error("cycle length select wrong");
  chk_timer_divide: assert property (@(posedge clk) // R11
    disable iff (reset)
    timerClockDivide == ($past(optWord_q[cowd_pkg::CYCLE_LEN_BIT]) ?
    cowd_pkg::DIV_LONG : cowd_pkg::DIV_SHORT))
    else $error("timer divide mismatch");
  chk_watchdog_polarity: assert property (@(posedge clk) // R05
    disable iff (reset)
    watchdogEnable == ~$past(optWord_q[cowd_pkg::WDOG_DIS_BIT]))
    else $error("watchdog enable wrong");
  chk_branch_cycles: assert property (@(posedge clk) // R06
    disable iff (reset)
    branchCycles == ($past(optWord_q[cowd_pkg::BRANCH_CYC_BIT]) ?
    cowd_pkg::BR_LONG : cowd_pkg::BR_SHORT))
    else $error("branch cycles wrong");
  chk_branch_select: assert property (@(posedge clk) // R06
    disable iff (reset)
    branchCycleSelect == $past(optWord_q[cowd_pkg::BRANCH_CYC_BIT]))
    else $error("branch cycle select wrong");
  chk_osc_type: assert property (@(posedge clk) // R07
    disable iff (reset)
    crystalSelect == $past(optWord_q[cowd_pkg::OSC_TYPE_BIT]))
    else $error("oscillator type wrong");
  chk_drive_power: assert property (@(posedge clk) // R08
    disable iff (reset)
    drivePowerSelect == $past(optWord_q[cowd_pkg::DRIVE_PWR_BIT]))
    else $error("drive power wrong");
  chk_protect_code: assert property (@(posedge clk) // R09
    disable iff (reset)
    writeProtectEnable ==
    ($past(optWord_q[cowd_pkg::PROT_MSB:cowd_pkg::PROT_LSB]) !=
    cowd_pkg::PROT_OFF_CODE))
    else $error("protect decode wrong");
  chk_option_walk: assert property (@(posedge clk) // R05 R07
    disable iff (reset)
    seq_option_walk |=>
    watchdogEnable == ~$past(progWordData[cowd_pkg::WDOG_DIS_BIT], 2) &&
    crystalSelect == $past(progWordData[cowd_pkg::OSC_TYPE_BIT], 2))
    else $error("option load not decoded");
  chk_spare_bits: assert property (@(posedge clk) // R03 R12
    disable iff (reset)
    $stable(optWord_q[cowd_pkg::CYCLE_LEN_BIT:cowd_pkg::BRANCH_CYC_BIT]) &&
    $stable(optWord_q[cowd_pkg::OSC_TYPE_BIT:cowd_pkg::PROT_LSB]) |=>
    $stable(writeProtectEnable) && $stable(watchdogEnable) &&
    $stable(oscPeriodsPerCycle) && $stable(branchCycles) &&
    $stable(crystalSelect) && $stable(drivePowerSelect) &&
    $stable(timerClockDivide) && $stable(cycleLengthSelect))
    else $error("ignored bits changed output");
endmodule : cowd_code_option_word_decode

// ---- cowd_pkg.sv ----
// constants for the configuration word decoder
// assumes 13-bit words delivered by the programming interface
package cowd_pkg;
  localparam int WORD_W = 13;
  localparam int CYCLE_LEN_BIT = 8;
  localparam int WDOG_DIS_BIT = 7;
  localparam int BRANCH_CYC_BIT = 6;
  localparam int SPARE_BIT = 5;
  localparam int OSC_TYPE_BIT = 4;
  localparam int DRIVE_PWR_BIT = 3;
  localparam int PROT_MSB = 2;
  localparam int PROT_LSB = 0;
  localparam logic [1:0] SEL_OPTION = 2'h0;
  localparam logic [1:0] SEL_ID1 = 2'h1;
  localparam logic [1:0] SEL_ID2 = 2'h2;
  localparam int ID_WORDS = 2;
  localparam logic [2:0] PROT_OFF_CODE = 3'h7;
  localparam logic [12:0] OPT_RESET = 13'h1fff;
  localparam logic [12:0] ID_RESET = 13'h0000;
  localparam logic [2:0] DIV_SHORT = 3'h2;
  localparam logic [2:0] DIV_LONG = 3'h4;
  localparam logic [1:0] BR_SHORT = 2'h1;
  localparam logic [1:0] BR_LONG = 2'h2;
endpackage : cowd_pkg

// ---- tb_top.sv ----
// testbench for the configuration word decoder
// assumes loads show at the outputs two edges after the strobe
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic progLoad = 1'b0;
  logic [1:0] progWordSel = 2'h0;
  logic [12:0] progWordData = 13'h0000;
  logic cls, wde, bcs, xs, dps, wpe;
  logic [2:0] ppc, tcd;
  logic [1:0] bc;
  logic [12:0] id1, id2, w;
  int n_mismatch = 0;
  int n_checks = 0;
  cowd_code_option_word_decode i_dut (.clk(clk), .reset(reset),
    .progLoad(progLoad), .progWordSel(progWordSel),
    .progWordData(progWordData), .cycleLengthSelect(cls),
    .oscPeriodsPerCycle(ppc), .watchdogEnable(wde),
    .branchCycleSelect(bcs), .branchCycles(bc), .crystalSelect(xs),
    .drivePowerSelect(dps), .writeProtectEnable(wpe),
    .timerClockDivide(tcd), .customerId1(id1), .customerId2(id2));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task cmp(input logic [12:0] seen, input logic [12:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task ld(input logic [1:0] s, input logic [12:0] d);
    progLoad = 1'b1;
    progWordSel = s;
    progWordData = d;
    @(negedge clk);
  endtask : ld
  task settle;
    progLoad = 1'b0;
    repeat (2) @(negedge clk);
  endtask : settle
  task opt(input logic [12:0] v);
    cmp({12'h000, cls}, {12'h000, v[8]});
    cmp({10'h000, ppc}, v[8] ? 13'h0004 : 13'h0002);
    cmp({10'h000, tcd}, v[8] ? 13'h0004 : 13'h0002);
    cmp({12'h000, wde}, {12'h000, ~v[7]});
    cmp({12'h000, bcs}, {12'h000, v[6]});
    cmp({11'h000, bc}, v[6] ? 13'h0002 : 13'h0001);
    cmp({12'h000, xs}, {12'h000, v[4]});
    cmp({12'h000, dps}, {12'h000, v[3]});
    cmp({12'h000, wpe}, {12'h000, v[2:0] != 3'h7});
  endtask : opt
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (500) @(negedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    opt(cowd_pkg::OPT_RESET);
    cmp(id1, cowd_pkg::ID_RESET);
    for (int i = 0; i < 16; i++)
    begin
      w = 13'(i) * 13'h0249 ^ (i[0] ? 13'h0030 : 13'h0000);
      ld(2'h0, w);
      settle();
      opt(w);
    end
    ld(2'h0, 13'h1e20);
    ld(2'h3, 13'h1fff);
    settle();
    opt(13'h0000);
    ld(2'h0, 13'h0000);
    settle();
    opt(13'h0000);
    for (int k = 0; k < 2; k++)
    begin
      ld(2'h1, k[0] ? 13'h05a3 : 13'h1a5c);
      ld(2'h2, k[0] ? 13'h1a5c : 13'h05a3);
      settle();
      cmp(id1, k[0] ? 13'h05a3 : 13'h1a5c);
      cmp(id2, k[0] ? 13'h1a5c : 13'h05a3);
    end
    opt(13'h0000);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    opt(cowd_pkg::OPT_RESET);
    cmp(id2, cowd_pkg::ID_RESET);
    report_and_stop();
  end
endmodule : tb_top
